// File: rtl/sfr_space_page_decoder.sv
// Register-space decoder with timed-access protected page selection.
// Assumes the CPU core holds one access per cycle and waits out o_acc_busy;
// peripheral read data arrive combinationally in the cycle of the strobe.
`timescale 1ns/1ps
`default_nettype none
`include "sfr_space_page_decoder_consts.svh"

module sfr_space_page_decoder
    import sfr_space_page_decoder_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_ce,
    input  wire logic       i_acc_rd,
    input  wire logic       i_acc_wr,
    input  wire logic       i_acc_direct,
    input  wire logic       i_acc_bit,
    input  wire logic [7:0] i_acc_addr,
    input  wire logic [2:0] i_acc_bit_idx,
    input  wire logic [7:0] i_acc_wdata,
    output logic            o_acc_busy,
    output logic [7:0]      o_acc_rdata,
    output logic            o_acc_rvalid,
    output logic            o_acc_reject,
    output logic            o_periph_rd,
    output logic            o_periph_wr,
    output logic [7:0]      o_periph_addr,
    output logic            o_periph_page,
    output logic [7:0]      o_periph_wdata,
    input  wire logic [7:0] i_periph_rdata,
    output logic            o_page_select,
    output logic            o_ta_open
);

    // Registered state
    bit_state_t bit_state_r, bit_state_nxt;
    ta_state_t  ta_state_r,  ta_state_nxt;
    logic [2:0] ta_cnt_r,    ta_cnt_nxt;
    logic       page_r,      page_nxt;
    logic [7:0] merge_r,     merge_nxt;
    logic [7:0] hold_addr_r, hold_addr_nxt;
    logic       hold_page_r, hold_page_nxt;
    logic [7:0] rdata_r,     rdata_nxt;
    logic       rvalid_r,    rvalid_nxt;
    logic       reject_r,    reject_nxt;

    // Decode of the incoming access
    logic       addr_paged;
    logic       addr_reserved;
    logic       ours;
    logic       bad_bit;
    logic       take;
    logic       is_page_sel;
    logic       is_ta_key;
    logic       internal;
    logic [7:0] page_sel_val;
    logic [7:0] bit_mask;
    logic       eff_page;

    sfr_addr_class u_class (
        .i_addr     (i_acc_addr),
        .i_page     (page_r),
        .o_paged    (addr_paged),
        .o_reserved (addr_reserved)
    );

    // Indirect or lower-half addresses belong to RAM, not to us
    assign ours = i_acc_direct && in_sfr_space(i_acc_addr)
                  && (i_acc_rd || i_acc_wr);
    // A bit operation on a byte-only location is not decoded
    assign bad_bit = i_acc_bit && !is_bit_addressable(i_acc_addr);
    // Reserved holes are refused rather than passed on
    assign take = ours && !bad_bit && !addr_reserved
                  && (bit_state_r == BS_IDLE) && i_ce;
    assign is_page_sel = (i_acc_addr == `SFR_PAGE_SEL_ADDR);
    assign is_ta_key   = (i_acc_addr == `SFR_TA_KEY_ADDR);
    assign internal    = is_page_sel || is_ta_key;
    // Unpaged locations always go out as page 0 so both pages alias
    assign eff_page    = addr_paged ? page_r : 1'b0;
    assign page_sel_val = {7'h00, page_r};
    assign bit_mask     = 8'h01 << i_acc_bit_idx;

    // Peripheral strobes; a bit write reads first, then writes merged
    always_comb begin
        o_periph_rd    = 1'b0;
        o_periph_wr    = 1'b0;
        o_periph_addr  = i_acc_addr;
        o_periph_page  = eff_page;
        o_periph_wdata = i_acc_wdata;
        if (bit_state_r == BS_MERGE) begin
            o_periph_wr    = i_ce;
            o_periph_addr  = hold_addr_r;
            o_periph_page  = hold_page_r;
            o_periph_wdata = merge_r;
        end else if (take && !internal) begin
            o_periph_rd = i_acc_rd || (i_acc_wr && i_acc_bit);
            o_periph_wr = i_acc_wr && !i_acc_bit;
        end
    end

    // CPU must wait while a bit write finishes its second cycle
    assign o_acc_busy = (bit_state_r == BS_MERGE);

    // Bit read-modify-write sequencing
    always_comb begin
        bit_state_nxt = bit_state_r;
        merge_nxt     = merge_r;
        hold_addr_nxt = hold_addr_r;
        hold_page_nxt = hold_page_r;
        case (bit_state_r)
            BS_IDLE: begin
                if (take && !internal && i_acc_wr && i_acc_bit) begin
                    // Only the addressed bit changes; others kept
                    merge_nxt = (i_periph_rdata & ~bit_mask)
                                | (i_acc_wdata[0] ? bit_mask : 8'h00);
                    hold_addr_nxt = i_acc_addr;
                    hold_page_nxt = eff_page;
                    bit_state_nxt = BS_MERGE;
                end
            end
            BS_MERGE: bit_state_nxt = BS_IDLE;
            default:  bit_state_nxt = BS_IDLE;
        endcase
    end

    // Timed-access key: AAh then 55h as consecutive register writes
    always_comb begin
        ta_state_nxt = ta_state_r;
        ta_cnt_nxt   = ta_cnt_r;
        case (ta_state_r)
            TA_LOCKED: begin
                if (take && i_acc_wr && is_ta_key
                    && i_acc_wdata == `SFR_TA_KEY_FIRST) begin
                    ta_state_nxt = TA_HALF;
                end
            end
            TA_HALF: begin
                // Any write between the two keys other than a repeated AAh key spoils it
                if (take && i_acc_wr) begin
                    if (is_ta_key
                        && i_acc_wdata == `SFR_TA_KEY_SECOND) begin
                        ta_state_nxt = TA_OPEN;
                        ta_cnt_nxt   = `SFR_TA_OPEN_CYCLES;
                    end else if (is_ta_key
                        && i_acc_wdata == `SFR_TA_KEY_FIRST) begin
                        ta_state_nxt = TA_HALF;
                    end else begin
                        ta_state_nxt = TA_LOCKED;
                    end
                end
            end
            TA_OPEN: begin
                // Closes after one protected write or when time runs out
                if (take && i_acc_wr && is_page_sel) begin
                    ta_state_nxt = TA_LOCKED;
                    ta_cnt_nxt   = 3'h0;
                end else if (ta_cnt_r <= 3'h1) begin
                    ta_state_nxt = TA_LOCKED;
                    ta_cnt_nxt   = 3'h0;
                end else begin
                    ta_cnt_nxt = ta_cnt_r - 3'h1;
                end
            end
            default: begin
                ta_state_nxt = TA_LOCKED;
                ta_cnt_nxt   = 3'h0;
            end
        endcase
    end

    assign o_ta_open = (ta_state_r == TA_OPEN);

    // Page select register; unlocked writes are dropped silently
    always_comb begin
        page_nxt = page_r;
        if (take && i_acc_wr && is_page_sel
            && ta_state_r == TA_OPEN) begin
            if (i_acc_bit) begin
                // Only bit 0 exists; other bit writes land on nothing
                if (i_acc_bit_idx == 3'(`SFR_PAGE_BIT_POS)) begin
                    page_nxt = i_acc_wdata[0];
                end
            end else begin
                page_nxt = i_acc_wdata[`SFR_PAGE_BIT_POS];
            end
        end
    end

    assign o_page_select = page_r;

    // Read data and answer flags
    always_comb begin
        logic [7:0] byte_val;
        byte_val   = 8'h00;
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        reject_nxt = ours && i_ce && (bit_state_r == BS_IDLE)
                     && (bad_bit || addr_reserved);
        if (take && i_acc_rd) begin
            if (is_page_sel) begin
                byte_val = page_sel_val;
            end else if (is_ta_key) begin
                byte_val = 8'h00;
            end else begin
                byte_val = i_periph_rdata;
            end
            if (i_acc_bit) begin
                rdata_nxt = {7'h00, byte_val[i_acc_bit_idx]};
            end else begin
                rdata_nxt = byte_val;
            end
            rvalid_nxt = 1'b1;
        end
    end

    assign o_acc_rdata  = rdata_r;
    assign o_acc_rvalid = rvalid_r;
    assign o_acc_reject = reject_r;

    // All state registers; i_ce low freezes everything
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bit_state_r <= BS_IDLE;
            ta_state_r  <= TA_LOCKED;
            ta_cnt_r    <= 3'h0;
            page_r      <= 1'(`SFR_PAGE_SEL_RESET);
            merge_r     <= 8'h00;
            hold_addr_r <= 8'h00;
            hold_page_r <= 1'b0;
            rdata_r     <= 8'h00;
            rvalid_r    <= 1'b0;
            reject_r    <= 1'b0;
        end else if (i_ce) begin
            bit_state_r <= bit_state_nxt;
            ta_state_r  <= ta_state_nxt;
            ta_cnt_r    <= ta_cnt_nxt;
            page_r      <= page_nxt;
            merge_r     <= merge_nxt;
            hold_addr_r <= hold_addr_nxt;
            hold_page_r <= hold_page_nxt;
            rdata_r     <= rdata_nxt;
            rvalid_r    <= rvalid_nxt;
            reject_r    <= reject_nxt;
        end
    end

endmodule // sfr_space_page_decoder

`default_nettype wire

// File: rtl/sfr_space_page_decoder_consts.svh
// Constants of the register-space page decoder: addresses, keys, counts.
// Assumes an 8-bit direct address and 8-bit register data.
`ifndef SFR_SPACE_PAGE_DECODER_CONSTS_SVH
`define SFR_SPACE_PAGE_DECODER_CONSTS_SVH

`define SFR_SPACE_LOW        8'h80
`define SFR_PAGE_SEL_ADDR    8'h91
`define SFR_TA_KEY_ADDR      8'hc7
`define SFR_TA_KEY_FIRST     8'haa
`define SFR_TA_KEY_SECOND    8'h55
`define SFR_PAGE_SEL_RESET   8'h00
`define SFR_PAGE_BIT_POS     0
`define SFR_TA_OPEN_CYCLES   3'h4

`endif

// File: rtl/sfr_space_page_decoder_pkg.sv
// Types and address decoding shared by the page decoder files.
// Assumes the constants header is on the include path.
`include "sfr_space_page_decoder_consts.svh"

package sfr_space_page_decoder_pkg;

    typedef enum logic {
        BS_IDLE,
        BS_MERGE
    } bit_state_t;

    typedef enum logic [1:0] {
        TA_LOCKED,
        TA_HALF,
        TA_OPEN
    } ta_state_t;

    typedef logic [7:0] sfr_addr_t;

    // Low nibble 0h or 8h means the location takes single-bit operations
    function automatic logic is_bit_addressable(input sfr_addr_t a);
        return (a[2:0] == 3'h0);
    endfunction

    // Direct address in the upper half lands in the register space
    function automatic logic in_sfr_space(input sfr_addr_t a);
        return (a >= `SFR_SPACE_LOW);
    endfunction

endpackage

// File: rtl/sfr_addr_class.sv
// Classifies a register-space address for a given page.
// Pure decode; the caller registers anything it keeps.
`timescale 1ns/1ps
`default_nettype none

module sfr_addr_class
    import sfr_space_page_decoder_pkg::*;
(
    input  wire logic [7:0] i_addr,
    input  wire logic       i_page,
    output logic            o_paged,
    output logic            o_reserved
);

    // Locations that resolve to a distinct register on page 1, or to a hole for FEh and FFh
    always_comb begin
        case (i_addr)
            8'hac, 8'had,
            8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6,
            8'hfe, 8'hff: o_paged = 1'b1;
            default:      o_paged = 1'b0;
        endcase
    end

    // Unoccupied holes; page 1 also leaves the top two empty
    always_comb begin
        case (i_addr)
            8'h84, 8'h85, 8'h9d, 8'h9e, 8'ha1, 8'hf1, 8'hfd:
                o_reserved = 1'b1;
            8'hfe, 8'hff:
                o_reserved = i_page;
            default:
                o_reserved = 1'b0;
        endcase
    end

endmodule // sfr_addr_class

`default_nettype wire

// File: bench/sfr_space_page_decoder_assertions.sv
// Checker for the register-space page decoder, bound to its top module.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module sfr_space_page_decoder_checker (
    input wire logic       i_ref_clk,
    input wire logic       i_nrst,
    input wire logic       i_ce,
    input wire logic       i_acc_rd,
    input wire logic       i_acc_wr,
    input wire logic       i_acc_direct,
    input wire logic       i_acc_bit,
    input wire logic [7:0] i_acc_addr,
    input wire logic [2:0] i_acc_bit_idx,
    input wire logic [7:0] i_acc_wdata,
    input wire logic       o_acc_busy,
    input wire logic [7:0] o_acc_rdata,
    input wire logic       o_acc_rvalid,
    input wire logic       o_acc_reject,
    input wire logic       o_periph_rd,
    input wire logic       o_periph_wr,
    input wire logic [7:0] o_periph_addr,
    input wire logic       o_periph_page,
    input wire logic [7:0] o_periph_wdata,
    input wire logic [7:0] i_periph_rdata,
    input wire logic       o_page_select,
    input wire logic       o_ta_open
);
    logic take;
    logic paged;
    logic strobe;

    // Direct request in the register space that the decoder may take
    assign take = i_ce && i_acc_direct && i_acc_addr[7] && !o_acc_busy;
    assign strobe = o_periph_rd || o_periph_wr;
    // Paged locations are kept here apart from the design's own decode
    assign paged = (o_periph_addr inside {8'hac, 8'had, 8'hfe, 8'hff})
        || (o_periph_addr >= 8'hb1 && o_periph_addr <= 8'hb6);

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    sequence key(logic [7:0] v);
        take && i_acc_wr && !i_acc_bit && i_acc_addr == 8'hc7
            && i_acc_wdata == v;
    endsequence
    sequence byte_read;
        take && i_acc_rd && !i_acc_bit && o_periph_rd;
    endsequence

    chk_no_indirect: assert property (
        (!i_acc_direct || !i_acc_addr[7]) && !o_acc_busy |-> !strobe)
        else $error("strobe for an access outside the space");
    chk_read_answer: assert property (
        byte_read |=> o_acc_rvalid && o_acc_rdata == $past(i_periph_rdata))
        else $error("read answer wrong");
    chk_bit_merge: assert property (
        take && i_acc_wr && i_acc_bit && o_periph_rd |=> o_acc_busy
            && o_periph_wr && o_periph_addr == $past(i_acc_addr))
        else $error("bit write merge cycle missing");
    chk_bit_refuse: assert property (
        take && (i_acc_rd || i_acc_wr) && i_acc_bit
            && i_acc_addr[2:0] != 3'h0 |=> o_acc_reject)
        else $error("bit op on byte location not refused");
    chk_local_regs: assert property (
        strobe |-> !(o_periph_addr inside {8'h91, 8'hc7}))
        else $error("local register leaked to peripheral");
    chk_page_guard: assert property (
        $changed(o_page_select) |-> $past(o_ta_open))
        else $error("page changed while locked");
    chk_key_opens: assert property (
        key(8'haa) ##1 key(8'h55) |=> o_ta_open)
        else $error("key pair did not open protection");
    chk_window_ends: assert property (
        $rose(o_ta_open) |-> ##[1:4] !o_ta_open)
        else $error("protection stayed open too long");
    chk_paged_route: assert property (
        strobe |-> o_periph_page == (paged & o_page_select))
        else $error("page routing wrong");
    chk_sel_readback: assert property (
        take && i_acc_rd && !i_acc_bit && i_acc_addr == 8'h91
            |=> o_acc_rdata == {7'h00, $past(o_page_select)})
        else $error("page select readback wrong");
endmodule // sfr_space_page_decoder_checker

bind sfr_space_page_decoder sfr_space_page_decoder_checker chk_i (.*);

`default_nettype wire

// File: bench/sfr_periph_model.sv
// Peripheral register model behind the decoder, one array holding both pages.
// Assumes read data are wanted in the cycle of the read strobe.
`timescale 1ns/1ps
`default_nettype none

module sfr_periph_model (
    input wire logic       i_clk,
    input wire logic       i_rd,
    input wire logic       i_wr,
    input wire logic [7:0] i_addr,
    input wire logic       i_page,
    input wire logic [7:0] i_wdata,
    output logic     [7:0] o_rdata
);
    logic [7:0] mem [512];

    // Each location starts at its own 8-bit address, so both pages start alike
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = i[7:0];
        end
    end

    // Without a strobe the data lines carry junk, never the last value
    always_comb begin
        o_rdata = i_rd ? mem[{i_page, i_addr}] : ~mem[{i_page, i_addr}];
    end

    always @(posedge i_clk) begin
        if (i_wr) begin
            mem[{i_page, i_addr}] <= i_wdata;
        end
    end
endmodule // sfr_periph_model

`default_nettype wire

// File: bench/sfr_space_page_decoder_tb.sv
// Self-checking bench: the CPU side is driven by tasks, peripherals modelled.
// Assumes the checker is bound and the peripheral model is compiled.
`timescale 1ns/1ps
`default_nettype none

module sfr_space_page_decoder_tb;
    // Mode bits are {direct, bit, write, read}
    localparam logic [3:0] RD = 4'h9, WR = 4'ha, BR = 4'hd, BW = 4'he;
    localparam logic [3:0] IW = 4'h2, NO = 4'h0;
    int err_count = 0;
    int checks_done = 0;
    logic i_ref_clk = 1'h0, i_nrst = 1'h0, i_ce = 1'h1;
    logic i_acc_rd = 1'h0, i_acc_wr = 1'h0;
    logic i_acc_direct = 1'h0, i_acc_bit = 1'h0;
    logic [7:0] i_acc_addr = 8'h00, i_acc_wdata = 8'h00;
    logic [2:0] i_acc_bit_idx = 3'h0;
    logic [7:0] o_acc_rdata, o_periph_addr, o_periph_wdata, i_periph_rdata;
    logic o_acc_busy, o_acc_rvalid, o_acc_reject, o_periph_rd;
    logic o_periph_wr, o_periph_page, o_page_select, o_ta_open;

    sfr_space_page_decoder dut (
        .i_ref_clk      (i_ref_clk),
        .i_nrst         (i_nrst),
        .i_ce           (i_ce),
        .i_acc_rd       (i_acc_rd),
        .i_acc_wr       (i_acc_wr),
        .i_acc_direct   (i_acc_direct),
        .i_acc_bit      (i_acc_bit),
        .i_acc_addr     (i_acc_addr),
        .i_acc_bit_idx  (i_acc_bit_idx),
        .i_acc_wdata    (i_acc_wdata),
        .o_acc_busy     (o_acc_busy),
        .o_acc_rdata    (o_acc_rdata),
        .o_acc_rvalid   (o_acc_rvalid),
        .o_acc_reject   (o_acc_reject),
        .o_periph_rd    (o_periph_rd),
        .o_periph_wr    (o_periph_wr),
        .o_periph_addr  (o_periph_addr),
        .o_periph_page  (o_periph_page),
        .o_periph_wdata (o_periph_wdata),
        .i_periph_rdata (i_periph_rdata),
        .o_page_select  (o_page_select),
        .o_ta_open      (o_ta_open)
    );
    sfr_periph_model peer (.i_clk(i_ref_clk), .i_rd(o_periph_rd),
        .i_wr(o_periph_wr), .i_addr(o_periph_addr), .i_page(o_periph_page),
        .i_wdata(o_periph_wdata), .o_rdata(i_periph_rdata));

    initial begin
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    task check(input string what, input logic [9:0] seen, logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One request per call, held until the next call replaces it
    task put(input logic [3:0] m, logic [7:0] a, logic [2:0] x,
             logic [7:0] d);
        @(posedge i_ref_clk);
        {i_acc_direct, i_acc_bit, i_acc_wr, i_acc_rd} <= m;
        i_acc_addr <= a;
        i_acc_bit_idx <= x;
        i_acc_wdata <= d;
    endtask

    // Request, release at the take edge, then judge the answer
    task get(input logic [3:0] m, logic [7:0] a, logic [2:0] x,
             logic [7:0] e, logic rj);
        put(m, a, x, 8'h00);
        put(NO, a, x, 8'h00);
        @(negedge i_ref_clk);
        check("answer", {o_acc_reject, o_acc_rvalid, 8'h00},
              {rj, m[0] & !rj, 8'h00});
        if (!rj) check("rdata", {2'h0, o_acc_rdata}, {2'h0, e});
    endtask

    task unlock;
        put(WR, 8'hc7, 3'h0, 8'haa);
        put(WR, 8'hc7, 3'h0, 8'h55);
    endtask

    // Page select write, then the page that must result
    task sel(input logic [7:0] d, logic p);
        put(WR, 8'h91, 3'h0, d);
        put(NO, 8'h00, 3'h0, 8'h00);
        @(negedge i_ref_clk);
        // Protection is shut after any page select write, taken or not
        check("page", {8'h00, o_page_select, o_ta_open}, {8'h00, p, 1'h0});
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole sequence needs under a hundred cycles; cut a hang short
    initial begin
        repeat (2000) @(posedge i_ref_clk);
        err_count++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge i_ref_clk);
        i_nrst <= 1'h1;
        @(negedge i_ref_clk);
        check("reset", {8'h00, o_page_select, o_ta_open}, 10'h000);
        get(RD, 8'h91, 3'h0, 8'h00, 1'h0);
        put(WR, 8'ha9, 3'h0, 8'h5a);
        get(RD, 8'ha9, 3'h0, 8'h5a, 1'h0);
        put(IW, 8'ha9, 3'h0, 8'h33);
        // Clock enable low: a write presented meanwhile must not land
        i_ce <= 1'h0;
        put(WR, 8'ha9, 3'h0, 8'h11);
        put(NO, 8'h00, 3'h0, 8'h00);
        i_ce <= 1'h1;
        get(RD, 8'ha9, 3'h0, 8'h5a, 1'h0);
        put(WR, 8'he8, 3'h0, 8'ha1);
        put(BW, 8'he8, 3'h2, 8'h01);
        repeat (2) put(NO, 8'h00, 3'h0, 8'h00);
        get(RD, 8'he8, 3'h0, 8'ha5, 1'h0);
        get(BR, 8'he8, 3'h2, 8'h01, 1'h0);
        get(BW, 8'he9, 3'h1, 8'h00, 1'h1);
        get(RD, 8'h84, 3'h0, 8'h00, 1'h1);
        sel(8'h01, 1'h0);
        // A write between the two keys spoils the unlock
        put(WR, 8'hc7, 3'h0, 8'haa);
        put(WR, 8'ha9, 3'h0, 8'h5a);
        put(WR, 8'hc7, 3'h0, 8'h55);
        sel(8'h01, 1'h0);
        unlock();
        sel(8'hff, 1'h1);
        get(RD, 8'h91, 3'h0, 8'h01, 1'h0);
        put(WR, 8'hac, 3'h0, 8'h77);
        get(RD, 8'hac, 3'h0, 8'h77, 1'h0);
        get(RD, 8'ha9, 3'h0, 8'h5a, 1'h0);
        unlock();
        repeat (5) put(NO, 8'h00, 3'h0, 8'h00);
        sel(8'h00, 1'h1);
        unlock();
        sel(8'h00, 1'h0);
        get(RD, 8'hac, 3'h0, 8'hac, 1'h0);
        unlock();
        sel(8'h01, 1'h1);
        @(posedge i_ref_clk);
        i_nrst <= 1'h0;
        repeat (2) @(posedge i_ref_clk);
        i_nrst <= 1'h1;
        @(negedge i_ref_clk);
        check("rerun", {9'h000, o_page_select}, 10'h000);
        print_verdict();
    end
endmodule // sfr_space_page_decoder_tb

`default_nettype wire
